// >>> shared/svsup_pkg.sv
`default_nettype none
package svsup_pkg;

  localparam logic [7:0] ADDR_CONTROL   = 8'h55;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h56;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h57;

  localparam int unsigned POS_LEVEL_LO  = 4;
  localparam int unsigned POS_RESET_ON  = 3;
  localparam int unsigned POS_ACTIVE    = 2;
  localparam int unsigned POS_COMP_OUT  = 1;
  localparam int unsigned POS_FLAG      = 0;

  localparam logic [3:0] LEVEL_OFF      = 4'h0;
  localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;

  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [1:0] INT_RESET      = 2'h0;

  localparam int unsigned CLK_MHZ           = 50;
  localparam int unsigned STARTUP_DELAY_US  = 50;
  localparam int unsigned SETTLE_DELAY_US   = 12;
  localparam int unsigned STARTUP_CYCLES    = STARTUP_DELAY_US * CLK_MHZ;
  localparam int unsigned SETTLE_CYCLES     = SETTLE_DELAY_US * CLK_MHZ;
  localparam int unsigned DELAY_W           = 12;

  typedef enum logic [1:0] {
    SVSUP_OFF,
    SVSUP_STARTUP,
    SVSUP_SETTLE,
    SVSUP_MONITOR
  } svsup_state_e;

  typedef struct packed {
    logic [3:0] level_select;
    logic       reset_on_low_enable;
    logic       low_voltage_flag;
  } svsup_ctrl_s;

endpackage
`default_nettype wire

// >>> design/svsup_top.sv
// Notes on behaviour
// - Level select zero disables supervisor; any non-zero value enables it.
// - Monitor active is read-only status; writing it does nothing.
// - Level code 1111 selects the external sense input against about 1.2 V.
// - Codes 0001 to 1110 pick one of 14 thresholds sent to the comparator.
// - Comparator low condition sets the low-voltage flag outside startup and settling delays.
// - Flag setting with reset-on-low enable requests power-on reset; else flag only.
// - Flag stays set until software clears it or brownout reset.
// - Clearing flag while condition persists sets it again immediately.
// - Change from zero to non-zero starts a startup delay of about 50 us.
// - Change between non-zero values after startup starts a settling delay of at most 12 us; during startup it restarts the startup delay.
// - During delays no flag, no reset request, monitor active held zero.
// - Brownout reset returns the supervisor to the disabled state.
// - Writable bits clear only on brownout reset, not power-on reset or clear.
// - Live comparator output readable as a read-only bit.
// - Layout: level 7:4, reset enable 3, active 2, comparator 1, flag 0.
`timescale 1ns/1ps
`default_nettype none
module svsup_top #(
  parameter int unsigned STARTUP_CYCLES = svsup_pkg::STARTUP_CYCLES,
  parameter int unsigned SETTLE_CYCLES  = svsup_pkg::SETTLE_CYCLES
) (
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output var  logic [7:0] RDATA,
  input  wire logic       COMP_LOW,
  output var  logic [3:0] LEVEL_SELECT,
  output var  logic       EXT_SENSE_SELECT,
  output var  logic       SUPPLY_ENABLE,
  output var  logic       POR_REQUEST,
  output var  logic       IRQ
);

  svsup_pkg::svsup_ctrl_s ctrl;
  svsup_pkg::svsup_state_e state;
  logic [svsup_pkg::DELAY_W-1:0] delay_cnt;
  logic       comp_meta;
  logic       comp_low;
  logic       monitor_active;
  logic       set_flag;
  logic       wr_ctrl;
  logic [3:0] new_level;
  logic [1:0] int_status;
  logic [1:0] int_mask;
  logic       delay_done;

  assign wr_ctrl   = WR && (ADDR == svsup_pkg::ADDR_CONTROL);
  assign new_level = WDATA[7:svsup_pkg::POS_LEVEL_LO];
  assign delay_done = (delay_cnt == '0);
  assign set_flag  = monitor_active && comp_low;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      comp_meta <= 1'b0;
      comp_low  <= 1'b0;
    end else begin
      comp_meta <= COMP_LOW;
      comp_low  <= comp_meta;
    end
  end

  // RST_B is the brownout reset; other resets never reach these bits
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl.level_select        <= new_level;
        ctrl.reset_on_low_enable <= WDATA[svsup_pkg::POS_RESET_ON];
      end
      if (set_flag)
        ctrl.low_voltage_flag <= 1'b1;
      else if (wr_ctrl)
        ctrl.low_voltage_flag <= WDATA[svsup_pkg::POS_FLAG];
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state     <= svsup_pkg::SVSUP_OFF;
      delay_cnt <= '0;
    end else if (wr_ctrl && new_level != ctrl.level_select) begin
      if (new_level == svsup_pkg::LEVEL_OFF) begin
        state     <= svsup_pkg::SVSUP_OFF;
        delay_cnt <= '0;
      end else if (ctrl.level_select == svsup_pkg::LEVEL_OFF || state == svsup_pkg::SVSUP_STARTUP) begin
        // Turned on from level zero, or startup not finished yet: the full startup wait applies
        state     <= svsup_pkg::SVSUP_STARTUP;
        delay_cnt <= svsup_pkg::DELAY_W'(STARTUP_CYCLES - 1);
      end else begin
        state     <= svsup_pkg::SVSUP_SETTLE;
        delay_cnt <= svsup_pkg::DELAY_W'(SETTLE_CYCLES - 1);
      end
    end else begin
      unique case (state)
        svsup_pkg::SVSUP_OFF:     state <= svsup_pkg::SVSUP_OFF;
        svsup_pkg::SVSUP_MONITOR: state <= svsup_pkg::SVSUP_MONITOR;
        svsup_pkg::SVSUP_STARTUP,
        svsup_pkg::SVSUP_SETTLE: begin
          if (delay_done)
            state <= svsup_pkg::SVSUP_MONITOR;
          else
            delay_cnt <= delay_cnt - 1'b1;
        end
      endcase
    end
  end

  assign monitor_active = (state == svsup_pkg::SVSUP_MONITOR);

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B)
      POR_REQUEST <= 1'b0;
    else
      POR_REQUEST <= set_flag && ctrl.reset_on_low_enable;
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LEVEL_SELECT     <= svsup_pkg::LEVEL_OFF;
      EXT_SENSE_SELECT <= 1'b0;
      SUPPLY_ENABLE    <= 1'b0;
    end else begin
      LEVEL_SELECT     <= ctrl.level_select;
      EXT_SENSE_SELECT <= (ctrl.level_select == svsup_pkg::LEVEL_EXTERNAL);
      SUPPLY_ENABLE    <= (ctrl.level_select != svsup_pkg::LEVEL_OFF);
    end
  end

  // Interrupt status: bit0 low-voltage event, bit1 startup or settling delay ran out
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      int_status <= svsup_pkg::INT_RESET;
      int_mask   <= svsup_pkg::INT_RESET;
      IRQ        <= 1'b0;
    end else begin
      if (WR && ADDR == svsup_pkg::ADDR_INT_MASK)
        int_mask <= WDATA[1:0];
      int_status[0] <= set_flag ||
        (int_status[0] && !(WR && ADDR == svsup_pkg::ADDR_INT_STATUS && WDATA[0]));
      int_status[1] <= (state != svsup_pkg::SVSUP_MONITOR && state != svsup_pkg::SVSUP_OFF && delay_done) ||
        (int_status[1] && !(WR && ADDR == svsup_pkg::ADDR_INT_STATUS && WDATA[1]));
      IRQ <= |(int_status & int_mask);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B)
      RDATA <= svsup_pkg::CONTROL_RESET;
    else if (RD) begin
      unique case (ADDR)
        svsup_pkg::ADDR_CONTROL:    RDATA <= {ctrl.level_select, ctrl.reset_on_low_enable,
                                              monitor_active, comp_low, ctrl.low_voltage_flag};
        svsup_pkg::ADDR_INT_STATUS: RDATA <= {6'h00, int_status};
        svsup_pkg::ADDR_INT_MASK:   RDATA <= {6'h00, int_mask};
        default:                    RDATA <= 8'h00;
      endcase
    end else
      RDATA <= 8'h00;
  end

  chk_flag_sticky: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    ctrl.low_voltage_flag && !wr_ctrl |=> ctrl.low_voltage_flag)
    else $error("flag dropped without write");
  chk_flag_reset: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    set_flag |=> ctrl.low_voltage_flag)
    else $error("flag lost while low");
  chk_delay_quiet: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !monitor_active |=> !POR_REQUEST)
    else $error("reset request during delay");
  chk_por_request: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    set_flag && ctrl.reset_on_low_enable |=> POR_REQUEST)
    else $error("missing reset request");
  chk_level_off: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    ctrl.level_select == svsup_pkg::LEVEL_OFF |-> !monitor_active ##1 !SUPPLY_ENABLE)
    else $error("supervisor on at level zero");
  chk_ext_select: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    ctrl.level_select == svsup_pkg::LEVEL_EXTERNAL |=> EXT_SENSE_SELECT)
    else $error("external channel not selected");
  chk_settle_start: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    wr_ctrl && state == svsup_pkg::SVSUP_MONITOR && new_level != ctrl.level_select &&
    new_level != svsup_pkg::LEVEL_OFF |=> state == svsup_pkg::SVSUP_SETTLE ##1 !monitor_active)
    else $error("settle delay not applied");
  chk_comp_sync: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    1'b1 |-> comp_low == $past(COMP_LOW, 2))
    else $error("sync stage mismatch");

  // Cycles spent in the current delay, counted apart from the down-counter
  logic [svsup_pkg::DELAY_W-1:0] wait_len;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B)
      wait_len <= '0;
    else if (wr_ctrl && new_level != ctrl.level_select)
      wait_len <= '0;
    else if (state == svsup_pkg::SVSUP_STARTUP || state == svsup_pkg::SVSUP_SETTLE)
      wait_len <= wait_len + 1'b1;
    else
      wait_len <= '0;
  end

  chk_startup_len: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state == svsup_pkg::SVSUP_STARTUP && delay_done |-> wait_len == svsup_pkg::DELAY_W'(STARTUP_CYCLES - 1))
    else $error("startup delay length wrong");
  chk_settle_len: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state == svsup_pkg::SVSUP_SETTLE && delay_done |-> wait_len == svsup_pkg::DELAY_W'(SETTLE_CYCLES - 1))
    else $error("settle delay length wrong");
  chk_flag_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    wr_ctrl && !WDATA[svsup_pkg::POS_FLAG] && !set_flag |=> !ctrl.low_voltage_flag)
    else $error("flag not cleared by write");
  chk_no_flag_delay: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    state != svsup_pkg::SVSUP_MONITOR && !ctrl.low_voltage_flag && !wr_ctrl |=> !ctrl.low_voltage_flag)
    else $error("flag set outside monitoring");
  chk_por_drop: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !set_flag |=> !POR_REQUEST)
    else $error("reset request without condition");
  chk_por_needs_en: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !ctrl.reset_on_low_enable |=> !POR_REQUEST)
    else $error("reset request while disabled");
  chk_supply_en: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    ctrl.level_select != svsup_pkg::LEVEL_OFF |=> SUPPLY_ENABLE)
    else $error("supervisor not enabled");
  chk_level_drive: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    1'b1 |=> LEVEL_SELECT == $past(ctrl.level_select))
    else $error("threshold drive lags");
  chk_ext_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    ctrl.level_select != svsup_pkg::LEVEL_EXTERNAL |=> !EXT_SENSE_SELECT)
    else $error("external channel wrongly selected");
  chk_off_state: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    ctrl.level_select == svsup_pkg::LEVEL_OFF |-> state == svsup_pkg::SVSUP_OFF)
    else $error("sequencer running at level zero");
  chk_level_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !wr_ctrl |=> ctrl.level_select == $past(ctrl.level_select))
    else $error("level changed without write");
  chk_reset_en_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !wr_ctrl |=> ctrl.reset_on_low_enable == $past(ctrl.reset_on_low_enable))
    else $error("reset enable changed without write");
  // Read data idle
  chk_rdata_idle: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !RD |=> RDATA == 8'h00)
    else $error("read data outside read cycle");
  // Interrupt level
  chk_irq_level: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    |(int_status & int_mask) |=> IRQ)
    else $error("interrupt not raised");
  // Mask holds
  chk_mask_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !(WR && ADDR == svsup_pkg::ADDR_INT_MASK) |=> int_mask == $past(int_mask))
    else $error("mask changed without write");
  // Status sticky
  chk_status_sticky: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    int_status[0] && !(WR && ADDR == svsup_pkg::ADDR_INT_STATUS) |=> int_status[0])
    else $error("status bit dropped without write");
  chk_startup: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    wr_ctrl && ctrl.level_select == svsup_pkg::LEVEL_OFF && new_level != svsup_pkg::LEVEL_OFF
    |=> state == svsup_pkg::SVSUP_STARTUP)
    else $error("startup delay not applied");

  cov_flag_set: cover property (@(posedge REF_CLK) disable iff (!RST_B) set_flag);
  cov_por: cover property (@(posedge REF_CLK) disable iff (!RST_B) POR_REQUEST);
  cov_monitor: cover property (@(posedge REF_CLK) disable iff (!RST_B)
    state == svsup_pkg::SVSUP_STARTUP ##1 monitor_active);
  cov_settle: cover property (@(posedge REF_CLK) disable iff (!RST_B) state == svsup_pkg::SVSUP_SETTLE);
  cov_ext_por: cover property (@(posedge REF_CLK) disable iff (!RST_B) EXT_SENSE_SELECT && POR_REQUEST);

endmodule // svsup_top
`default_nettype wire

// >>> tb/svsup_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Comparator model: output is only meaningful while the supervisor is powered
module svsup_partner (
  input  wire logic [3:0] level_select,
  input  wire logic       ext_sense_select,
  input  wire logic       supply_enable,
  input  wire logic       supply_low,
  input  wire logic       ext_low,
  output var  logic       comp_low
);
  // Powered-off comparator reports no condition; external channel replaces the internal one
  always_comb begin
    comp_low = supply_enable && (level_select != 4'h0) && (ext_sense_select ? ext_low : supply_low);
  end
endmodule // svsup_partner
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; $display("wrong value %s exp %h got %h", nm, exp, got); end end
module testbench;
  logic       ref_clk = 1'b0;
  logic       rst_b   = 1'b0;
  logic [7:0] addr    = 8'h00;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic       supply_low = 1'b0;
  logic       ext_low    = 1'b0;
  logic [7:0] rdata, d;
  logic [3:0] level_sel;
  logic       comp_low, ext_sel, sup_en, por_req, irq;
  int         num_errors = 0;
  int         n_tests    = 0;
  // Short delays keep the run brief; real counts are 2500 and 600 cycles
  svsup_top #(.STARTUP_CYCLES(8), .SETTLE_CYCLES(4)) u_dut (
    .REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .COMP_LOW(comp_low), .LEVEL_SELECT(level_sel), .EXT_SENSE_SELECT(ext_sel), .SUPPLY_ENABLE(sup_en),
    .POR_REQUEST(por_req), .IRQ(irq));
  svsup_partner u_partner (
    .level_select(level_sel), .ext_sense_select(ext_sel), .supply_enable(sup_en),
    .supply_low(supply_low), .ext_low(ext_low), .comp_low(comp_low));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
    @(posedge ref_clk) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk) begin rd <= 1'b1; addr <= a; end
    @(posedge ref_clk) rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset_state();
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("control", 8'h00, d)
    `CHK("enable", 1'b0, sup_en)
    rd_reg(8'h60, d);
    `CHK("unmapped", 8'h00, d)
  endtask
  task automatic t_startup();
    wr_reg(svsup_pkg::ADDR_CONTROL, 8'h16);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("ctrl startup", 8'h10, d)
    `CHK("enable", 1'b1, sup_en)
    `CHK("level", 4'h1, level_sel)
    `CHK("ext sel", 1'b0, ext_sel)
    wait_cyc(12);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("active", 8'h14, d)
  endtask
  task automatic t_flag_latch();
    supply_low <= 1'b1;
    wait_cyc(5);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("flag set", 8'h17, d)
    `CHK("no por", 1'b0, por_req)
    `CHK("irq masked", 1'b0, irq)
    wr_reg(svsup_pkg::ADDR_INT_MASK, 8'h01);
    wait_cyc(2);
    `CHK("irq", 1'b1, irq)
    supply_low <= 1'b0;
    wait_cyc(5);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("flag held", 8'h15, d)
    wr_reg(svsup_pkg::ADDR_CONTROL, 8'h10);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("flag clr", 8'h14, d)
    wr_reg(svsup_pkg::ADDR_INT_STATUS, 8'h01);
    wait_cyc(2);
    `CHK("irq clr", 1'b0, irq)
  endtask
  task automatic t_reassert();
    wr_reg(svsup_pkg::ADDR_CONTROL, 8'h18);
    supply_low <= 1'b1;
    wait_cyc(5);
    `CHK("por", 1'b1, por_req)
    wr_reg(svsup_pkg::ADDR_CONTROL, 8'h18);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("flag again", 8'h1f, d)
    supply_low <= 1'b0;
  endtask
  task automatic t_settle();
    // Let the synchroniser drain so the clear is not overridden
    wait_cyc(3);
    wr_reg(svsup_pkg::ADDR_CONTROL, 8'h18);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("flag cleared", 8'h1c, d)
    ext_low <= 1'b1;
    wr_reg(svsup_pkg::ADDR_CONTROL, 8'hf8);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("settle", 8'hf8, d & 8'hfd)
    `CHK("settle por", 1'b0, por_req)
    `CHK("ext sel", 1'b1, ext_sel)
    wait_cyc(10);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("after settle", 8'hff, d)
    `CHK("ext por", 1'b1, por_req)
    ext_low <= 1'b0;
    wait_cyc(4);
    wr_reg(svsup_pkg::ADDR_CONTROL, 8'h00);
    wait_cyc(2);
    rd_reg(svsup_pkg::ADDR_CONTROL, d);
    `CHK("off", 8'h00, d)
    `CHK("off enable", 1'b0, sup_en)
  endtask
  task automatic t_brownout();
    wr_reg(svsup_pkg::ADDR_CONTROL, 8'h29);
    #3 rst_b = 1'b0;
    #40 rst_b = 1'b1;
    // Brownout is the only reset of the register bits
    t_reset_state();
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #3 rst_b = 1'b1;
    t_reset_state();
    t_startup();
    t_flag_latch();
    t_reassert();
    t_settle();
    t_brownout();
    end_of_test();
  end
  initial begin
    #20000;
    num_errors++;
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
